// >>> tb/tb_time_output_config_decoder.sv
// Self-checking bench for the time output configuration decoder.
// Assumes tocfd_sink as record consumer and shortened divider values.
`timescale 1ns/10ps
`default_nettype none
module tb_time_output_config_decoder;
	localparam int BDIV = 64;
	localparam int IBDIV = 40;
	localparam int IEDIV = 400;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic utc_valid = 1'b0;
	logic [6:0] utc_year = 7'h00;
	logic [8:0] utc_doy = 9'h001;
	logic [2:0] utc_wday = 3'h0;
	logic [4:0] utc_hour = 5'h00;
	logic [5:0] utc_min = 6'h00;
	logic [5:0] utc_sec = 6'h00;
	logic [9:0] utc_ms = 10'h000;
	logic ms_tick = 1'b0;
	logic sync_in = 1'b0;
	logic dst_season = 1'b0;
	logic leap_pending = 1'b0;
	logic ontime_pulse, disp_pm, remote_fmt, baud_tick, irig_tick;
	logic irig_code_e, irig_mod_en, irig_am_mode, rec_valid, rec_ready;
	logic [4:0] disp_hour;
	logic [1:0] serial_fmt;
	logic [tocfd_pkg::REC_W-1:0] rec_data;
	logic stall = 1'b0;
	logic slow = 1'b0;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	tocfd_pkg::tocfd_rec_s r;

	tocfd_top #(.BAUD300_DIV(BDIV), .IRIG_B_DIV(IBDIV), .IRIG_E_DIV(IEDIV)) DUT (
		.core_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .utc_valid, .utc_year, .utc_doy, .utc_wday, .utc_hour, .utc_min,
		.utc_sec, .utc_ms, .ms_tick, .sync_in, .dst_season, .leap_pending, .ontime_pulse,
		.disp_hour, .disp_pm, .serial_fmt, .remote_fmt, .baud_tick, .irig_tick,
		.irig_code_e, .irig_mod_en, .irig_am_mode, .rec_data, .rec_valid, .rec_ready);
	tocfd_sink sink (.core_clk, .rst_b, .rec_data, .rec_valid, .stall, .slow, .rec_ready);

	initial forever #2 core_clk = ~core_clk;

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Generous ceiling: the whole sequence needs well under 10000 cycles
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			miscompares++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		chk(n < 16, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
		repeat (3) @(posedge core_clk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h00000000, rd, err);
		chk(rd, exp);
		chk(err, eerr);
	endtask

	task automatic send_utc(input int doy, input int wd, input int h, input int s);
		@(posedge core_clk);
		utc_year <= 7'h21;
		utc_doy <= 9'(doy);
		utc_wday <= 3'(wd);
		utc_hour <= 5'(h);
		// Whole hours, so the 2:00:00 season point can be reached
		utc_min <= 6'h00;
		utc_sec <= 6'(s);
		utc_valid <= 1'b1;
		@(posedge core_clk);
		utc_valid <= 1'b0;
	endtask

	task automatic get_rec;
		int n;
		n = 0;
		while (sink.q.size() == 0 && n < 200)
		begin
			@(posedge core_clk);
			n++;
		end
		chk(n < 200, 1'b1);
		if (n < 200)
			r = sink.q.pop_front();
	endtask

	task automatic period(input bit irig, output int p);
		repeat (2)
		begin
			p = 0;
			do
			begin
				@(posedge core_clk);
				p++;
			end
			while ((irig ? irig_tick : baud_tick) !== 1'b1 && p < 2000);
		end
	endtask

	task automatic t_reset;
		rchk(tocfd_pkg::ADDR_CFG, 32'h00000004, 1'b0);
		rchk(tocfd_pkg::ADDR_ZONE, 32'h00000000, 1'b0);
		rchk(tocfd_pkg::ADDR_DELAY, 32'h00000000, 1'b0);
		rchk(tocfd_pkg::ADDR_FMT, 32'h00000000, 1'b0);
		rchk(tocfd_pkg::ADDR_STAT, 32'h00000008, 1'b0);
		rchk(8'h20, 32'h00000000, 1'b1);
		$display("test reset done");
	endtask

	task automatic t_fmt;
		logic [1:0] es [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
		for (int i = 0; i < 6; i++)
		begin
			wreg(tocfd_pkg::ADDR_FMT, 32'(i));
			chk(serial_fmt, es[i]);
			chk(remote_fmt, (i % 2) != 0);
		end
		$display("test formats done");
	endtask

	task automatic t_baud;
		int p;
		for (int s = 0; s < 6; s++)
		begin
			wreg(tocfd_pkg::ADDR_FMT, 32'(s << 4));
			period(1'b0, p);
			chk(p, BDIV >> s);
		end
		$display("test baud done");
	endtask

	task automatic t_irig;
		int p;
		for (int s = 0; s < 4; s++)
		begin
			wreg(tocfd_pkg::ADDR_FMT, 32'(s << 8));
			chk(irig_code_e, s >= 2);
			chk(irig_mod_en, (s % 2) == 0);
			period(1'b1, p);
			chk(p, s >= 2 ? IEDIV : IBDIV);
		end
		sync_in <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(irig_mod_en, 1'b1);
		wreg(tocfd_pkg::ADDR_CFG, 32'h00000000);
		chk(irig_am_mode, 1'b0);
		wreg(tocfd_pkg::ADDR_CFG, 32'h00000004);
		chk(irig_am_mode, 1'b1);
		$display("test irig done");
	endtask

	task automatic t_zone;
		logic [7:0] zt [7] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h12};
		leap_pending <= 1'b1;
		wreg(tocfd_pkg::ADDR_ZONE, 32'h00000005);
		send_utc(1, 0, 3, 5);
		get_rec();
		chk(r.hour, 5'h16);
		chk({r.year, r.doy, r.wday}, {7'h20, 9'h16E, 3'h6});
		chk({r.month, r.mday, r.min}, {4'hC, 5'h1F, 6'h00});
		chk({r.utc_hour, r.leap_sec}, {5'h03, 1'b1});
		chk({r.zone, r.sync}, {5'h05, 1'b1});
		chk(disp_hour, 5'h16);
		wreg(tocfd_pkg::ADDR_CFG, 32'h00000005);
		send_utc(1, 0, 3, 6);
		get_rec();
		chk({disp_hour, disp_pm}, {5'h0A, 1'b1});
		chk(r.hour, 5'h16);
		wreg(tocfd_pkg::ADDR_CFG, 32'h00000004);
		foreach (zt[i])
		begin
			wreg(tocfd_pkg::ADDR_ZONE, 32'(zt[i]));
			send_utc(50, 3, 12, i);
			get_rec();
			chk(r.hour, 5'(12 - zt[i][7:4] * 10 - zt[i][3:0]));
		end
		leap_pending <= 1'b0;
		$display("test zone done");
	endtask

	task automatic t_dst;
		wreg(tocfd_pkg::ADDR_ZONE, 32'h00000000);
		wreg(tocfd_pkg::ADDR_CFG, 32'h00000006);
		dst_season <= 1'b1;
		send_utc(100, 2, 1, 0);
		get_rec();
		chk({r.hour, r.dst}, {5'h01, 1'b0});
		send_utc(100, 2, 2, 0);
		send_utc(100, 2, 3, 0);
		get_rec();
		get_rec();
		chk({r.hour, r.dst}, {5'h04, 1'b1});
		rchk(tocfd_pkg::ADDR_STAT, 32'h0000000B, 1'b0);
		wreg(tocfd_pkg::ADDR_CFG, 32'h00000004);
		send_utc(100, 2, 5, 0);
		get_rec();
		chk({r.hour, r.dst}, {5'h05, 1'b0});
		dst_season <= 1'b0;
		$display("test daylight done");
	endtask

	task automatic pulse_ms(input logic [9:0] ms, input logic exp);
		@(posedge core_clk);
		ms_tick <= 1'b1;
		utc_ms <= ms;
		@(posedge core_clk);
		ms_tick <= 1'b0;
		@(posedge core_clk);
		chk(ontime_pulse, exp);
	endtask

	task automatic t_delay;
		wreg(tocfd_pkg::ADDR_DELAY, 32'h00000123);
		pulse_ms(10'h36D, 1'b1);
		pulse_ms(10'h36E, 1'b0);
		$display("test delay done");
	endtask

	task automatic t_fifo;
		stall <= 1'b1;
		for (int i = 0; i < 40; i++)
			send_utc(5, 1, 10, i);
		rchk(tocfd_pkg::ADDR_STAT, 32'h00000015, 1'b0);
		wreg(tocfd_pkg::ADDR_STAT, 32'h00000010);
		rchk(tocfd_pkg::ADDR_STAT, 32'h00000005, 1'b0);
		slow <= 1'b1;
		stall <= 1'b0;
		repeat (300) @(posedge core_clk);
		chk(sink.q.size() >= 32, 1'b1);
		foreach (sink.q[i])
			chk(sink.q[i].sec, 32'(i));
		rchk(tocfd_pkg::ADDR_STAT, 32'h00000009, 1'b0);
		slow <= 1'b0;
		$display("test buffer done");
	endtask

	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset();
		t_fmt();
		t_baud();
		t_irig();
		t_zone();
		t_dst();
		t_delay();
		t_fifo();
		close_out();
	end
endmodule
`default_nettype wire

// >>> tb/tocfd_sink.sv
// Record consumer standing behind the decoder's record stream.
// Assumes core_clk; the bench steers stalls through stall and slow.
`timescale 1ns/10ps
`default_nettype none
module tocfd_sink (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [tocfd_pkg::REC_W-1:0] rec_data,
	input wire logic rec_valid,
	input wire logic stall,
	input wire logic slow,
	output logic rec_ready
);
	tocfd_pkg::tocfd_rec_s q[$];
	logic phase_ff;
	// Slow mode takes a record only every other cycle
	assign rec_ready = !stall && !(slow && phase_ff);
	always @(posedge core_clk)
	begin
		phase_ff <= rst_b ? ~phase_ff : 1'b0;
		if (rst_b && rec_valid && rec_ready)
			q.push_back(tocfd_pkg::tocfd_rec_s'(rec_data));
	end
endmodule
`default_nettype wire

// >>> verilog/tocfd_fifo.sv
// Record FIFO with a registered output stage.
// Assumes one clock; the drain side may hold ready low for any time.
`timescale 1ns/10ps
`default_nettype none
module tocfd_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst_b,
	tocfd_strm_if.snk wr,
	tocfd_strm_if.src rd,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [0:DEPTH-1];
	logic [AW:0] wptr_ff;
	logic [AW:0] rptr_ff;
	logic [W-1:0] out_data_ff;
	logic out_valid_ff;
	wire [AW:0] level = wptr_ff - rptr_ff;
	wire push = wr.valid & ~full;
	wire load = ~empty & (~out_valid_ff | rd.ready);

	assign full = (level == (AW+1)'(DEPTH));
	assign empty = (level == '0);
	assign wr.ready = ~full;
	assign rd.data = out_data_ff;
	assign rd.valid = out_valid_ff;

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wptr_ff[AW-1:0]] <= wr.data;
		if (load)
			out_data_ff <= mem[rptr_ff[AW-1:0]];
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			out_valid_ff <= 1'b0;
		end
		else
		begin
			wptr_ff <= wptr_ff + (AW+1)'(push);
			rptr_ff <= rptr_ff + (AW+1)'(load);
			out_valid_ff <= load | (out_valid_ff & ~rd.ready);
		end
	end
endmodule
`default_nettype wire

// >>> verilog/tocfd_pkg.sv
// Shared constants for the time output configuration decoder.
// Assumes a single 250 MHz core clock and an APB register bus.
`default_nettype none
package tocfd_pkg;
	localparam int CLK_HZ = 250000000;
	localparam int BAUD_MIN = 300;
	localparam int IRIG_B_HZ = 1000;
	localparam int IRIG_E_HZ = 100;
	localparam int BAUD300_DIV = CLK_HZ / BAUD_MIN;
	localparam int IRIG_B_DIV = CLK_HZ / IRIG_B_HZ;
	localparam int IRIG_E_DIV = CLK_HZ / IRIG_E_HZ;
	localparam int FIFO_DEPTH = 32;

	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_ZONE = 8'h04;
	localparam logic [7:0] ADDR_DELAY = 8'h08;
	localparam logic [7:0] ADDR_FMT = 8'h0C;
	localparam logic [7:0] ADDR_STAT = 8'h10;

	localparam int CFG_H12_BIT = 0;
	localparam int CFG_DST_BIT = 1;
	localparam int CFG_AM_BIT = 2;
	localparam int FMT_DATA_LSB = 0;
	localparam int FMT_BAUD_LSB = 4;
	localparam int FMT_IRIG_LSB = 8;
	localparam int STAT_OVF_BIT = 4;

	localparam logic [2:0] CFG_RST = 3'h4;
	localparam logic [7:0] ZONE_RST = 8'h00;
	localparam logic [11:0] DELAY_RST = 12'h000;
	localparam logic [2:0] DSEL_RST = 3'h0;
	localparam logic [2:0] BSEL_RST = 3'h0;
	localparam logic [1:0] ISEL_RST = 2'h0;
	localparam logic [2:0] DSEL_MAX = 3'h5;
	localparam logic [2:0] BSEL_MAX = 3'h5;

	localparam logic [9:0] MS_PER_SEC = 10'h3E8;
	localparam logic [5:0] HOUR_DAY = 6'h18;
	localparam logic [5:0] HOUR_2DAY = 6'h30;
	localparam logic [4:0] ZONE_MAX = 5'h17;
	localparam logic [4:0] DST_HOUR = 5'h02;
	localparam logic [8:0] DAYS_YEAR = 9'h16D;
	localparam logic [8:0] DAYS_LEAP = 9'h16E;
	localparam logic [6:0] YEAR_MAX = 7'h63;
	localparam logic [2:0] WDAY_MAX = 3'h6;
	localparam logic [8:0] CUM_DAYS [0:11] = '{9'h000, 9'h01F, 9'h03B, 9'h05A, 9'h078,
		9'h097, 9'h0B5, 9'h0D4, 9'h0F3, 9'h111, 9'h130, 9'h14E};

	typedef struct packed {
		logic sync;
		logic dst;
		logic leap_sec;
		logic [6:0] year;
		logic [8:0] doy;
		logic [3:0] month;
		logic [4:0] mday;
		logic [2:0] wday;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
		logic [4:0] utc_hour;
		logic [9:0] ms;
		logic [4:0] zone;
	} tocfd_rec_s;
	localparam int REC_W = $bits(tocfd_rec_s);
endpackage
`default_nettype wire

// >>> verilog/tocfd_strm_if.sv
// Valid/ready stream carrier between the decoder and its record FIFO.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
`default_nettype none
interface tocfd_strm_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> verilog/tocfd_top.sv
// Applies configuration switches to the time outputs of the clock.
// Assumes time and status inputs come from logic on core_clk.
`timescale 1ns/10ps
`default_nettype none
module tocfd_top #(
	parameter int BAUD300_DIV = tocfd_pkg::BAUD300_DIV,
	parameter int IRIG_B_DIV = tocfd_pkg::IRIG_B_DIV,
	parameter int IRIG_E_DIV = tocfd_pkg::IRIG_E_DIV
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic utc_valid,
	input wire logic [6:0] utc_year,
	input wire logic [8:0] utc_doy,
	input wire logic [2:0] utc_wday,
	input wire logic [4:0] utc_hour,
	input wire logic [5:0] utc_min,
	input wire logic [5:0] utc_sec,
	input wire logic [9:0] utc_ms,
	input wire logic ms_tick,
	input wire logic sync_in,
	input wire logic dst_season,
	input wire logic leap_pending,
	output logic ontime_pulse,
	output logic [4:0] disp_hour,
	output logic disp_pm,
	output logic [1:0] serial_fmt,
	output logic remote_fmt,
	output logic baud_tick,
	output logic irig_tick,
	output logic irig_code_e,
	output logic irig_mod_en,
	output logic irig_am_mode,
	output logic [tocfd_pkg::REC_W-1:0] rec_data,
	output logic rec_valid,
	input wire logic rec_ready
);
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [2:0] cfg_ff;
	logic [7:0] zone_ff;
	logic [11:0] delay_ff;
	logic [2:0] dsel_ff;
	logic [2:0] bsel_ff;
	logic [1:0] isel_ff;
	logic ovf_ff;
	logic dst_ff;
	logic ontime_ff;
	logic [4:0] disp_hour_ff;
	logic disp_pm_ff;
	logic [1:0] serial_fmt_ff;
	logic remote_fmt_ff;
	logic [19:0] baud_cnt_ff;
	logic baud_tick_ff;
	logic [21:0] irig_cnt_ff;
	logic irig_tick_ff;
	logic irig_e_ff;
	logic irig_mod_ff;
	logic irig_am_ff;
	tocfd_pkg::tocfd_rec_s rec_ff;
	logic rec_pend_ff;
	logic fifo_full;
	logic fifo_empty;

	tocfd_strm_if #(.W(tocfd_pkg::REC_W)) push_if ();
	tocfd_strm_if #(.W(tocfd_pkg::REC_W)) pop_if ();

	// Register bus decode; one wait-free access cycle after setup
	wire apb_setup = psel & ~penable;
	wire apb_acc = psel & penable & pready_ff;
	wire apb_wr = apb_acc & pwrite;
	wire hit_cfg = (paddr == tocfd_pkg::ADDR_CFG);
	wire hit_zone = (paddr == tocfd_pkg::ADDR_ZONE);
	wire hit_delay = (paddr == tocfd_pkg::ADDR_DELAY);
	wire hit_fmt = (paddr == tocfd_pkg::ADDR_FMT);
	wire hit_stat = (paddr == tocfd_pkg::ADDR_STAT);
	wire hit_any = hit_cfg | hit_zone | hit_delay | hit_fmt | hit_stat;
	wire [31:0] rd_fmt = {22'h0, isel_ff, 1'b0, bsel_ff, 1'b0, dsel_ff};
	wire [31:0] rd_stat = {27'h0, ovf_ff, fifo_empty, fifo_full, dst_ff, sync_in};
	wire [31:0] rd_mux = hit_cfg ? {29'h0, cfg_ff} :
		hit_zone ? {24'h0, zone_ff} :
		hit_delay ? {20'h0, delay_ff} :
		hit_fmt ? rd_fmt :
		hit_stat ? rd_stat : 32'h0;

	wire cfg_h12 = cfg_ff[tocfd_pkg::CFG_H12_BIT];
	wire cfg_dst = cfg_ff[tocfd_pkg::CFG_DST_BIT];
	wire cfg_am = cfg_ff[tocfd_pkg::CFG_AM_BIT];

	// Zone digits to hours; a 7-bit sum above 23 is clamped, sums past 127 wrap first
	wire [6:0] zone_raw = {3'h0, zone_ff[7:4]} * 7'h0A + {3'h0, zone_ff[3:0]};
	wire [4:0] zone_hr = (zone_raw > {2'h0, tocfd_pkg::ZONE_MAX}) ? tocfd_pkg::ZONE_MAX :
		zone_raw[4:0];

	// Hour biased by one day so the subtraction never goes negative
	wire [5:0] h_add = {1'b0, utc_hour} + tocfd_pkg::HOUR_DAY + {5'h0, dst_ff}
		- {1'b0, zone_hr};
	wire day_back = (h_add < tocfd_pkg::HOUR_DAY);
	wire day_fwd = (h_add >= tocfd_pkg::HOUR_2DAY);
	wire [5:0] h_fwd = h_add - tocfd_pkg::HOUR_2DAY;
	wire [5:0] h_mid = h_add - tocfd_pkg::HOUR_DAY;
	wire [4:0] loc_hour = day_back ? h_add[4:0] : day_fwd ? h_fwd[4:0] : h_mid[4:0];

	// Two-digit year, leap every fourth year within one century
	wire [6:0] y_prev = (utc_year == 7'h00) ? tocfd_pkg::YEAR_MAX : utc_year - 7'h01;
	wire [6:0] y_next = (utc_year == tocfd_pkg::YEAR_MAX) ? 7'h00 : utc_year + 7'h01;
	wire [8:0] days_cur = (utc_year[1:0] == 2'h0) ? tocfd_pkg::DAYS_LEAP : tocfd_pkg::DAYS_YEAR;
	wire [8:0] days_prev = (y_prev[1:0] == 2'h0) ? tocfd_pkg::DAYS_LEAP : tocfd_pkg::DAYS_YEAR;
	wire first_day = (utc_doy == 9'h001);
	wire last_day = (utc_doy == days_cur);
	wire [8:0] doy_back = first_day ? days_prev : utc_doy - 9'h001;
	wire [8:0] doy_fwd = last_day ? 9'h001 : utc_doy + 9'h001;
	wire [8:0] loc_doy = day_back ? doy_back : day_fwd ? doy_fwd : utc_doy;
	wire [6:0] loc_year = (day_back & first_day) ? y_prev : (day_fwd & last_day) ? y_next :
		utc_year;
	wire [2:0] wd_back = (utc_wday == 3'h0) ? tocfd_pkg::WDAY_MAX : utc_wday - 3'h1;
	wire [2:0] wd_fwd = (utc_wday == tocfd_pkg::WDAY_MAX) ? 3'h0 : utc_wday + 3'h1;
	wire [2:0] loc_wday = day_back ? wd_back : day_fwd ? wd_fwd : utc_wday;
	wire [8:0] loc_md = doy_to_md(loc_doy, loc_year[1:0] == 2'h0);

	function automatic logic [8:0] doy_to_md(input logic [8:0] doy, input logic leap);
		logic [8:0] st;
		logic [3:0] mon;
		logic [8:0] day;
		mon = 4'h1;
		day = doy;
		for (int m = 0; m < 12; m++)
		begin
			st = tocfd_pkg::CUM_DAYS[m] + {8'h0, leap & (m >= 2)};
			if (doy > st)
			begin
				mon = 4'(m + 1);
				day = doy - st;
			end
		end
		return {mon, day[4:0]};
	endfunction

	// Next record; one per received second
	tocfd_pkg::tocfd_rec_s nxt_rec;
	always_comb
	begin
		nxt_rec.sync = sync_in;
		nxt_rec.dst = dst_ff;
		nxt_rec.leap_sec = leap_pending;
		nxt_rec.year = loc_year;
		nxt_rec.doy = loc_doy;
		nxt_rec.month = loc_md[8:5];
		nxt_rec.mday = loc_md[4:0];
		nxt_rec.wday = loc_wday;
		nxt_rec.hour = loc_hour;
		nxt_rec.min = utc_min;
		nxt_rec.sec = utc_sec;
		nxt_rec.utc_hour = utc_hour;
		nxt_rec.ms = utc_ms;
		nxt_rec.zone = zone_hr;
	end

	// A record waiting on a full FIFO stalls; a newer one then drops
	wire rec_drop = utc_valid & rec_pend_ff & ~push_if.ready;
	wire rec_load = utc_valid & ~rec_drop;
	wire nxt_pend = rec_load | (rec_pend_ff & ~push_if.ready);
	wire ovf_clr = apb_wr & hit_stat & pwdata[tocfd_pkg::STAT_OVF_BIT];
	wire nxt_ovf = rec_drop | (ovf_ff & ~ovf_clr);
	assign push_if.data = rec_ff;
	assign push_if.valid = rec_pend_ff;

	// Seasonal change only at local 2:00:00, and off means standard time
	wire at_two = (loc_hour == tocfd_pkg::DST_HOUR) & (utc_min == 6'h00) & (utc_sec == 6'h00);
	wire nxt_dst = ~cfg_dst ? 1'b0 : (utc_valid & at_two) ? dst_season : dst_ff;

	wire [4:0] h12_val = (loc_hour == 5'h00) ? 5'h0C : (loc_hour > 5'h0C) ? loc_hour - 5'h0C :
		loc_hour;
	wire [4:0] nxt_disp = cfg_h12 ? h12_val : loc_hour;
	wire nxt_pm = cfg_h12 & (loc_hour >= 5'h0C);

	// Delay digits in whole milliseconds
	wire [9:0] delay_ms = {6'h0, delay_ff[11:8]} * 10'h064 + {6'h0, delay_ff[7:4]} * 10'h00A
		+ {6'h0, delay_ff[3:0]};
	wire [9:0] ontime_at = (delay_ms == 10'h000) ? 10'h000 : tocfd_pkg::MS_PER_SEC - delay_ms;
	wire nxt_ontime = ms_tick & (utc_ms == ontime_at);

	wire [2:0] dsel = (dsel_ff > tocfd_pkg::DSEL_MAX) ? 3'h0 : dsel_ff;
	wire [1:0] nxt_sfmt = (dsel >= 3'h3) ? 2'(dsel - 3'h3) : dsel[1:0];
	wire [2:0] bsel = (bsel_ff > tocfd_pkg::BSEL_MAX) ? 3'h0 : bsel_ff;
	wire [19:0] baud_lim = 20'(BAUD300_DIV >> bsel) - 20'h00001;
	wire baud_wrap = (baud_cnt_ff >= baud_lim);
	wire irig_e = isel_ff[1];
	wire irig_sig = isel_ff[0];
	wire [21:0] irig_lim = irig_e ? 22'(IRIG_E_DIV - 1) : 22'(IRIG_B_DIV - 1);
	wire irig_wrap = (irig_cnt_ff >= irig_lim);

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			prdata_ff <= 32'h0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= apb_setup;
			pslverr_ff <= apb_setup & ~hit_any;
			if (apb_setup)
				prdata_ff <= pwrite ? 32'h0 : rd_mux;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			cfg_ff <= tocfd_pkg::CFG_RST;
			zone_ff <= tocfd_pkg::ZONE_RST;
			delay_ff <= tocfd_pkg::DELAY_RST;
			dsel_ff <= tocfd_pkg::DSEL_RST;
			bsel_ff <= tocfd_pkg::BSEL_RST;
			isel_ff <= tocfd_pkg::ISEL_RST;
		end
		else if (apb_wr)
		begin
			if (hit_cfg)
				cfg_ff <= pwdata[2:0];
			if (hit_zone)
				zone_ff <= pwdata[7:0];
			if (hit_delay)
				delay_ff <= pwdata[11:0];
			if (hit_fmt)
			begin
				dsel_ff <= pwdata[tocfd_pkg::FMT_DATA_LSB +: 3];
				bsel_ff <= pwdata[tocfd_pkg::FMT_BAUD_LSB +: 3];
				isel_ff <= pwdata[tocfd_pkg::FMT_IRIG_LSB +: 2];
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			rec_ff <= '0;
			rec_pend_ff <= 1'b0;
			ovf_ff <= 1'b0;
			dst_ff <= 1'b0;
			disp_hour_ff <= 5'h00;
			disp_pm_ff <= 1'b0;
		end
		else
		begin
			rec_pend_ff <= nxt_pend;
			ovf_ff <= nxt_ovf;
			dst_ff <= nxt_dst;
			if (rec_load)
			begin
				rec_ff <= nxt_rec;
				disp_hour_ff <= nxt_disp;
				disp_pm_ff <= nxt_pm;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ontime_ff <= 1'b0;
			serial_fmt_ff <= 2'h0;
			remote_fmt_ff <= 1'b0;
			baud_cnt_ff <= 20'h0;
			baud_tick_ff <= 1'b0;
			irig_cnt_ff <= 22'h0;
			irig_tick_ff <= 1'b0;
			irig_e_ff <= 1'b0;
			irig_mod_ff <= 1'b0;
			// Matches the switch reset so the output agrees with it out of reset and follows it one cycle late
			irig_am_ff <= tocfd_pkg::CFG_RST[tocfd_pkg::CFG_AM_BIT];
		end
		else
		begin
			ontime_ff <= nxt_ontime;
			serial_fmt_ff <= nxt_sfmt;
			remote_fmt_ff <= dsel[0];
			baud_cnt_ff <= baud_wrap ? 20'h0 : baud_cnt_ff + 20'h1;
			baud_tick_ff <= baud_wrap;
			irig_cnt_ff <= irig_wrap ? 22'h0 : irig_cnt_ff + 22'h1;
			irig_tick_ff <= irig_wrap;
			irig_e_ff <= irig_e;
			irig_mod_ff <= ~(irig_sig & ~sync_in);
			irig_am_ff <= cfg_am;
		end
	end

	tocfd_fifo #(.W(tocfd_pkg::REC_W), .DEPTH(tocfd_pkg::FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.wr(push_if),
		.rd(pop_if),
		.full(fifo_full),
		.empty(fifo_empty)
	);

	assign pop_if.ready = rec_ready;
	assign rec_data = pop_if.data;
	assign rec_valid = pop_if.valid;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign ontime_pulse = ontime_ff;
	assign disp_hour = disp_hour_ff;
	assign disp_pm = disp_pm_ff;
	assign serial_fmt = serial_fmt_ff;
	assign remote_fmt = remote_fmt_ff;
	assign baud_tick = baud_tick_ff;
	assign irig_tick = irig_tick_ff;
	assign irig_code_e = irig_e_ff;
	assign irig_mod_en = irig_mod_ff;
	assign irig_am_mode = irig_am_ff;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_ontime_point: assert property (nxt_ontime |=> ontime_ff ##1 !ontime_ff)
		else $error("on-time pulse missing or long");
	a_zone_zero: assert property ((rec_load && zone_ff == 8'h00 && !dst_ff)
		|=> rec_ff.hour == $past(utc_hour))
		else $error("zero zone does not give UTC hour");
	a_dst_off: assert property (!cfg_dst |=> !dst_ff)
		else $error("daylight offset with switch off");
	a_dst_hold: assert property ((dst_ff != $past(dst_ff)) |-> ($past(at_two && utc_valid)
		|| !$past(cfg_dst)))
		else $error("season change away from 2 AM");
	a_disp_range: assert property (rec_load && cfg_h12 |=> disp_hour_ff inside {[1:12]})
		else $error("12-hour display out of range");
	a_out_24h: assert property (rec_pend_ff |-> rec_ff.hour < 5'h18)
		else $error("record hour not 24-hour");
	a_fmt_map: assert property (##1 remote_fmt_ff == $past(dsel[0])
		&& serial_fmt_ff == $past(dsel) % 3)
		else $error("format switch mapping wrong");
	a_baud_wrap: assert property (baud_wrap |=> baud_tick_ff && baud_cnt_ff == 20'h0)
		else $error("baud divider did not wrap");
	a_sig_mute: assert property (irig_sig && !sync_in |=> !irig_mod_en)
		else $error("code not muted while unsynchronized");
	a_am_select: assert property (##1 irig_am_mode == $past(cfg_am))
		else $error("AM mode does not follow switch");
	a_sync_char: assert property (rec_load |=> rec_ff.sync == $past(sync_in))
		else $error("record sync flag stale");
	a_ovf_sticky: assert property (rec_drop |=> ovf_ff)
		else $error("dropped record not flagged");

	c_day_back: cover property (rec_load && day_back && first_day);
	c_overflow: cover property (rec_drop);
	c_dst_change: cover property (cfg_dst && utc_valid && at_two && dst_season != dst_ff);
	c_pm_display: cover property (rec_load && cfg_h12 && nxt_pm);
endmodule
`default_nettype wire
